// File: pms_map.vh
// Register offsets, fields and timing constants of the power-mode controller
`ifndef PMS_MAP_VH
`define PMS_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define PMS_ADDR_W          4
`define PMS_REG_CTRL        4'h0
`define PMS_REG_SLEEP       4'h1
`define PMS_REG_IDLE        4'h2
`define PMS_REG_STATUS      4'h3
`define PMS_REG_SCRATCH     4'h4

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define PMS_CTRL_BALANCED   0
`define PMS_CTRL_AUTO_EN    1
`define PMS_CTRL_AUTO_OPT   2
`define PMS_CTRL_IMMEDIATE  3

// Power-mode register field
`define PMS_SLEEP_REQ_BIT   0

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define PMS_CTRL_RST        4'h0
`define PMS_IDLE_RST        16'h0064
`define PMS_SLEEP_RST       16'h03E8

////////////////////////////////////////////////////////////////////////////////
// Power states
`define PMS_ST_RESET        3'h0
`define PMS_ST_PERF         3'h1
`define PMS_ST_BAL          3'h2
`define PMS_ST_STANDBY      3'h3
`define PMS_ST_DEEP         3'h4

// Clock settings
`define PMS_CLK_MAX         2'h3
`define PMS_CLK_BAL         2'h2
`define PMS_CLK_MIN         2'h1
`define PMS_CLK_OFF         2'h0

`endif

// File: pms_power_mode.v
// Power-mode state machine with register port and clock control
`timescale 1ns/1ps
`include "pms_map.vh"
// What this block does
// - Host reset input forces the reset state from any mode.
// - Leaving reset enters the configured default work mode.
// - Default work mode is performance unless software selects balanced.
// - Any host transaction moves an idle state to a work mode, except a sleep command in standby, which enters deep sleep.
// - When enabled, inactivity returns a work mode to an idle state.
// - In reset, writes are discarded and reads return FFFF.
// - Performance mode runs clocks at maximum and allows flash operations.
// - Balanced mode runs clocks at fixed settings, flash operations allowed.
// - With the second auto-sleep option, host inactivity leads into the standby state.
// - Standby gates or minimises clocks to most internal cores.
// - Waking from standby adds no delay to the triggering access.
// - Deep sleep disables oscillator, input buffers and high-current parts.
// - Writing the sleep request bit puts the device into deep sleep.
// - Immediate sleep command enters deep sleep at once.
// - First auto-sleep option enters deep sleep directly on inactivity.
// - Second option: standby on inactivity, deep sleep after set period.
// - Register contents survive deep sleep entry and return.
// - Deep sleep ends on any host access or host reset.
module pms_power_mode
#(
    parameter IDLE_W = 16
)
(
    input  wire                   clk,
    input  wire                   srst,
    input  wire                   host_reset_in_n,
    input  wire [`PMS_ADDR_W-1:0] addr,
    input  wire [15:0]            wrData,
    input  wire                   wrStb,
    input  wire                   rdStb,
    output reg  [15:0]            rdData,
    output reg  [2:0]             powerState,
    output reg  [1:0]             coreClkSel,
    output reg                    flashOpEn,
    output reg                    oscEn,
    output reg                    inBufEn
);

////////////////////////////////////////////////////////////////////////////////
// Host reset pin synchroniser
reg  [2:0]          rstSync;
reg                 hostRstLvl;
wire                hostRst;

always @(posedge clk)
begin
    if (srst)
    begin
        rstSync    <= 3'h7;
        hostRstLvl <= 1'b0;
    end
    else
    begin
        rstSync <= {rstSync[1:0], host_reset_in_n};
        if (rstSync[1] == rstSync[2])
            hostRstLvl <= ~rstSync[2];
    end
end

assign hostRst = hostRstLvl;

////////////////////////////////////////////////////////////////////////////////
// Registers and state
reg                 balancedDef;
reg                 autoEn;
reg                 autoOpt;
reg  [IDLE_W-1:0]   idlePeriod;
reg  [IDLE_W-1:0]   sleepPeriod;
reg  [15:0]         scratch;
reg  [2:0]          state;
reg  [2:0]          resumeState;
reg  [IDLE_W-1:0]   idleCnt;
reg  [2:0]          next_state;
reg  [15:0]         idleRd;
reg  [15:0]         sleepRd;

// Period registers widened to the bus
always @*
begin
    idleRd                = 16'h0000;
    sleepRd               = 16'h0000;
    idleRd[IDLE_W-1:0]    = idlePeriod;
    sleepRd[IDLE_W-1:0]   = sleepPeriod;
end

wire                access   = wrStb | rdStb;
wire                inReset  = (state == `PMS_ST_RESET);
wire                regWr    = wrStb & ~inReset;
wire                wrCtrl   = regWr & (addr == `PMS_REG_CTRL);
wire                sleepCmd = (regWr & (addr == `PMS_REG_SLEEP)
                               & wrData[`PMS_SLEEP_REQ_BIT])
                               | (wrCtrl & wrData[`PMS_CTRL_IMMEDIATE]);
wire [2:0]          defWork  = balancedDef ? `PMS_ST_BAL : `PMS_ST_PERF;
wire                isWork   = (state == `PMS_ST_PERF) | (state == `PMS_ST_BAL);
wire                idleHit  = (idleCnt >= idlePeriod);
wire                sleepHit = (idleCnt >= sleepPeriod);

////////////////////////////////////////////////////////////////////////////////
// Register writes; kept through deep sleep
always @(posedge clk)
begin
    if (srst)
    begin
        balancedDef <= 1'b0;
        autoEn      <= 1'b0;
        autoOpt     <= 1'b0;
        idlePeriod  <= `PMS_IDLE_RST;
        sleepPeriod <= `PMS_SLEEP_RST;
        scratch     <= 16'h0000;
    end
    else if (regWr)
    begin
        case (addr)
            `PMS_REG_CTRL:
            begin
                balancedDef <= wrData[`PMS_CTRL_BALANCED];
                autoEn      <= wrData[`PMS_CTRL_AUTO_EN];
                autoOpt     <= wrData[`PMS_CTRL_AUTO_OPT];
            end
            `PMS_REG_IDLE:
                idlePeriod <= wrData[IDLE_W-1:0];
            `PMS_REG_STATUS:
                sleepPeriod <= wrData[IDLE_W-1:0];
            `PMS_REG_SCRATCH:
                scratch <= wrData;
            default:
                scratch <= scratch;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Inactivity timer
always @(posedge clk)
begin
    if (srst || hostRst || access || state == `PMS_ST_DEEP)
        idleCnt <= {IDLE_W{1'b0}};
    else if (state == `PMS_ST_STANDBY && autoOpt && !sleepHit)
        idleCnt <= idleCnt + 1'b1;
    else if (isWork && !idleHit)
        idleCnt <= idleCnt + 1'b1;
    else if (isWork || state == `PMS_ST_STANDBY)
        idleCnt <= (isWork && autoEn) ? {IDLE_W{1'b0}} : idleCnt;
end

////////////////////////////////////////////////////////////////////////////////
// Next-state logic
always @*
begin
    next_state = state;
    case (state)
        `PMS_ST_RESET:
            next_state = defWork;
        `PMS_ST_PERF, `PMS_ST_BAL:
        begin
            if (sleepCmd)
                next_state = `PMS_ST_DEEP;
            else if (!access && autoEn && idleHit)
                next_state = autoOpt ? `PMS_ST_STANDBY
                                     : `PMS_ST_DEEP;
            else if (wrCtrl)
                next_state = wrData[`PMS_CTRL_BALANCED] ? `PMS_ST_BAL
                                                        : `PMS_ST_PERF;
        end
        `PMS_ST_STANDBY:
        begin
            if (sleepCmd)
                next_state = `PMS_ST_DEEP;
            else if (access)
                next_state = resumeState;
            else if (autoOpt && sleepHit)
                next_state = `PMS_ST_DEEP;
        end
        `PMS_ST_DEEP:
            if (access)
                next_state = resumeState;
        default:
            next_state = `PMS_ST_RESET;
    endcase
    if (hostRst)
        next_state = `PMS_ST_RESET;
end

always @(posedge clk)
begin
    if (srst)
    begin
        state       <= `PMS_ST_RESET;
        resumeState <= `PMS_ST_PERF;
    end
    else
    begin
        state <= next_state;
        if (next_state == `PMS_ST_PERF || next_state == `PMS_ST_BAL)
            resumeState <= next_state;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Clock and power controls from the next state
always @(posedge clk)
begin
    if (srst)
    begin
        coreClkSel <= `PMS_CLK_OFF;
        flashOpEn  <= 1'b0;
        oscEn      <= 1'b1;
        inBufEn    <= 1'b1;
        powerState <= `PMS_ST_RESET;
    end
    else
    begin
        powerState <= next_state;
        oscEn      <= 1'b1;
        inBufEn    <= 1'b1;
        flashOpEn  <= 1'b0;
        case (next_state)
            `PMS_ST_PERF:
            begin
                coreClkSel <= `PMS_CLK_MAX;
                flashOpEn  <= 1'b1;
            end
            `PMS_ST_BAL:
            begin
                coreClkSel <= `PMS_CLK_BAL;
                flashOpEn  <= 1'b1;
            end
            `PMS_ST_STANDBY:
                coreClkSel <= `PMS_CLK_MIN;
            `PMS_ST_DEEP:
            begin
                coreClkSel <= `PMS_CLK_OFF;
                oscEn      <= 1'b0;
                inBufEn    <= 1'b0;
            end
            default:
                coreClkSel <= `PMS_CLK_OFF;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read data, one cycle after the strobe
always @(posedge clk)
begin
    if (srst)
        rdData <= 16'h0000;
    else if (rdStb && inReset)
        rdData <= 16'hFFFF;
    else if (rdStb)
    begin
        case (addr)
            `PMS_REG_CTRL:
                rdData <= {13'h0000, autoOpt, autoEn, balancedDef};
            `PMS_REG_IDLE:
                rdData <= idleRd;
            `PMS_REG_STATUS:
                rdData <= sleepRd;
            `PMS_REG_SLEEP:
                rdData <= {13'h0000, state};
            `PMS_REG_SCRATCH:
                rdData <= scratch;
            default:
                rdData <= 16'h0000;
        endcase
    end
    else
        rdData <= 16'h0000;
end

endmodule

// File: pms_power_mode_props.sv
// Checker for the power-mode controller ports
`timescale 1ns/1ps
`include "pms_map.vh"
module pms_power_mode_props
(
    input wire                   clk,
    input wire                   srst,
    input wire                   host_reset_in_n,
    input wire [`PMS_ADDR_W-1:0] addr,
    input wire [15:0]            wrData,
    input wire                   wrStb,
    input wire                   rdStb,
    input wire [15:0]            rdData,
    input wire [2:0]             powerState,
    input wire [1:0]             coreClkSel,
    input wire                   flashOpEn,
    input wire                   oscEn,
    input wire                   inBufEn
);
reg  [5:0] pinHist;
reg  [2:0] lastWork;
wire       pinOk = &pinHist;
wire       work  = powerState == `PMS_ST_PERF || powerState == `PMS_ST_BAL;
wire       idle  = powerState == `PMS_ST_STANDBY || powerState == `PMS_ST_DEEP;
always @(posedge clk)
begin
    pinHist <= srst ? 6'h3F : {pinHist[4:0], host_reset_in_n};
    lastWork <= srst ? `PMS_ST_PERF : (work ? powerState : lastWork);
end
default clocking cb @(posedge clk); endclocking
default disable iff (srst);
property p_perf;
    powerState == `PMS_ST_PERF |-> coreClkSel == `PMS_CLK_MAX && flashOpEn;
endproperty
a_perf: assert property (p_perf) else $error("performance clocks wrong");
property p_bal;
    powerState == `PMS_ST_BAL |-> coreClkSel == `PMS_CLK_BAL && flashOpEn;
endproperty
a_bal: assert property (p_bal) else $error("balanced clocks wrong");
property p_stby;
    powerState == `PMS_ST_STANDBY |-> coreClkSel <= `PMS_CLK_MIN;
endproperty
a_stby: assert property (p_stby) else $error("standby clocks high");
property p_deep;
    powerState == `PMS_ST_DEEP |-> !oscEn && !inBufEn;
endproperty
a_deep: assert property (p_deep) else $error("deep sleep resources on");
property p_wake;
    idle && rdStb && pinOk |=> powerState == $past(lastWork);
endproperty
a_wake: assert property (p_wake) else $error("wake mode wrong");
property p_sleep;
    work && wrStb && addr == `PMS_REG_SLEEP && wrData[0] && pinOk |=> powerState == `PMS_ST_DEEP;
endproperty
a_sleep: assert property (p_sleep) else $error("sleep bit ignored");
property p_imm;
    work && wrStb && addr == `PMS_REG_CTRL && wrData[3] && pinOk |=> powerState == `PMS_ST_DEEP;
endproperty
a_imm: assert property (p_imm) else $error("immediate sleep ignored");
property p_rstRd;
    rdStb && powerState == `PMS_ST_RESET |=> rdData == 16'hFFFF;
endproperty
a_rstRd: assert property (p_rstRd) else $error("reset read data wrong");
property p_rst;
    !host_reset_in_n [*5] |=> powerState == `PMS_ST_RESET;
endproperty
a_rst: assert property (p_rst) else $error("host reset ignored");
endmodule
bind pms_power_mode pms_power_mode_props i_props (.clk(clk), .srst(srst),
    .host_reset_in_n(host_reset_in_n), .addr(addr), .wrData(wrData), .wrStb(wrStb),
    .rdStb(rdStb), .rdData(rdData), .powerState(powerState), .coreClkSel(coreClkSel),
    .flashOpEn(flashOpEn), .oscEn(oscEn), .inBufEn(inBufEn));

// File: pms_host.sv
// Host processor model on the register port
`timescale 1ns/1ps
module pms_host
(
    input  wire        clk,
    input  wire [15:0] rdData,
    output reg  [3:0]  addr,
    output reg  [15:0] wrData,
    output reg         wrStb,
    output reg         rdStb,
    output reg         hostRstN
);
initial
begin
    {addr, wrData, wrStb, rdStb, hostRstN} = 23'h1;
end
task wr(input [3:0] a, input [15:0] d);
begin
    @(posedge clk);
    {addr, wrData, wrStb} <= {a, d, 1'b1};
    @(posedge clk);
    {addr, wrData, wrStb} <= {~a, ~d, 1'b0};
end
endtask
task rd(input [3:0] a, output [15:0] d);
begin
    @(posedge clk);
    {addr, rdStb} <= {a, 1'b1};
    @(posedge clk);
    {addr, rdStb} <= {~a, 1'b0};
    #1 d = rdData;
end
endtask
task pin(input v);
begin
    @(posedge clk);
    hostRstN <= v;
end
endtask
endmodule

// File: testbench.sv
// Self-checking bench of the power-mode controller
`timescale 1ns/1ps
`include "pms_map.vh"
module testbench;
reg         clk = 0;
reg         srst = 1;
wire [3:0]  addr;
wire [15:0] wrData, rdData;
wire        wrStb, rdStb, hostRstN, flashOpEn, oscEn, inBufEn;
wire [2:0]  powerState;
wire [1:0]  coreClkSel;
integer     num_errors = 0;
integer     cmp_count = 0;
reg  [15:0] d;
reg  [15:0] lf = 16'h0041;
always #5 clk = ~clk;
pms_host i_host (.clk(clk), .rdData(rdData), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .hostRstN(hostRstN));
pms_power_mode #(.IDLE_W(16)) i_dut (.clk(clk), .srst(srst), .host_reset_in_n(hostRstN),
    .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
    .powerState(powerState), .coreClkSel(coreClkSel), .flashOpEn(flashOpEn),
    .oscEn(oscEn), .inBufEn(inBufEn));
function [15:0] lfsr(input [15:0] v);
    lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
endfunction
task chk(input [15:0] seen, input [15:0] exp);
begin
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
        num_errors = num_errors + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
end
endtask
task st(input integer n, input [2:0] e);
begin
    repeat (n) @(posedge clk);
    #1 chk({13'h0, powerState}, {13'h0, e});
end
endtask
task test_done;
begin
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
end
endtask
initial
begin
    #100000;
    num_errors = num_errors + 1;
    test_done;
end
initial
begin
    repeat (10) @(posedge clk);
    srst <= 0;
    st(2, `PMS_ST_PERF);
    i_host.rd(`PMS_REG_IDLE, d);
    chk(d, `PMS_IDLE_RST);
    i_host.rd(`PMS_REG_STATUS, d);
    chk(d, `PMS_SLEEP_RST);
    lf = lfsr(lf);
    i_host.wr(`PMS_REG_SCRATCH, lf);
    i_host.rd(4'hF, d);
    chk(d, 16'h0000);
    $display("registers done");
    i_host.wr(`PMS_REG_CTRL, 16'h0001);
    st(1, `PMS_ST_BAL);
    i_host.wr(`PMS_REG_SLEEP, 16'h0001);
    st(1, `PMS_ST_DEEP);
    chk({14'h0, oscEn, inBufEn}, 16'h0000);
    i_host.rd(`PMS_REG_SCRATCH, d);
    chk(d, lf);
    st(0, `PMS_ST_BAL);
    i_host.wr(`PMS_REG_CTRL, 16'h0009);
    st(1, `PMS_ST_DEEP);
    i_host.rd(`PMS_REG_SCRATCH, d);
    chk(d, lf);
    st(0, `PMS_ST_BAL);
    $display("sleep entry done");
    i_host.wr(`PMS_REG_IDLE, 16'h0005);
    i_host.wr(`PMS_REG_CTRL, 16'h0002);
    repeat (4)
    begin
        repeat (3) @(posedge clk);
        i_host.rd(`PMS_REG_IDLE, d);
    end
    st(2, `PMS_ST_PERF);
    st(8, `PMS_ST_DEEP);
    i_host.rd(`PMS_REG_SCRATCH, d);
    st(0, `PMS_ST_PERF);
    i_host.wr(`PMS_REG_STATUS, 16'h0006);
    i_host.wr(`PMS_REG_CTRL, 16'h0006);
    st(9, `PMS_ST_STANDBY);
    i_host.rd(`PMS_REG_SCRATCH, d);
    st(0, `PMS_ST_PERF);
    st(9, `PMS_ST_STANDBY);
    st(8, `PMS_ST_DEEP);
    $display("auto sleep done");
    i_host.wr(`PMS_REG_CTRL, 16'h0000);
    i_host.pin(1'b0);
    st(6, `PMS_ST_RESET);
    i_host.wr(`PMS_REG_CTRL, 16'h0001);
    i_host.rd(`PMS_REG_SCRATCH, d);
    chk(d, 16'hFFFF);
    i_host.pin(1'b1);
    st(6, `PMS_ST_PERF);
    $display("host reset done");
    test_done;
end
endmodule
